// ==== rtl/mrg_gate_ctrl.v ====
// Our own choices: the address map and the APB interface to the registers.
`timescale 1ns/10ps
`include "mrg_consts.vh"
// Overview of operation
// - Gate turns on when control pin or control bit 2 at 0x11 requests it.
// - Overcurrent held past deglitch time sets overcurrent flag; gate off unless its protect select is 1.
// - After overcurrent ends, pin or enable bit may switch the gate on again.
// - Supply, battery, or enabled watchdog faults block or remove the gate drive.
// - Gate short check happens only after the short-detect delay; short keeps gate low unless its select is 1.
// - Overvoltage sets its flag; bit 5 of 0x11 chooses gate off or unchanged.
// - Overvoltage flag clears on status read once overvoltage is gone.
// - Before turn-on, source test current, wait leak time, need source above supply.
// - Failed leakage test keeps gate off and sets the load-leak flag.
// - Logic undervoltage sets power-on-reset flag, gate off, drives reset pin low.
// - Enabled watchdog fault clears watchdog status, sets watchdog fault, gate off.
// - External reset pin low sets external-reset flag and switches gate off.
// - Overcurrent sets flag and summary; gate off unless its protect select is 1.
// - Gate short sets flag and summary; gate off unless its protect select is 1.
// - Source short while enabled sets flag and summary; off unless select is 1.
// - Turn-on with any low-side driver on sets flag; off unless select is 1.
// - Watchdog disable applies only when watchdog enable bit set; bit resets to 0.
module mrg_gate_ctrl (
    input wire i_sys_clk,
    input wire i_rst,
    input wire i_psel,
    input wire i_penable,
    input wire i_pwrite,
    input wire [`MRG_ADDR_W-1:0] i_paddr,
    input wire [31:0] i_pwdata,
    output reg [31:0] o_prdata,
    output wire o_pready,
    output wire o_pslverr,
    input wire i_main_relay_ctrl_pin,
    input wire i_overcurrent_cmp,
    input wire i_gate_short_cmp,
    input wire i_source_short_cmp,
    input wire i_source_above_vdd,
    input wire i_vdd_undervoltage,
    input wire i_bat_overvoltage,
    input wire i_bat_undervoltage,
    input wire i_watchdog_fault,
    input wire i_reset_pin_n,
    input wire [7:0] i_low_side_drivers,
    output reg o_main_relay_gate,
    output reg o_leak_test_current,
    output wire o_reset_pin_n_out,
    output wire o_reset_pin_n_oe,
    output wire o_irq
);
    localparam ST_OFF = 2'd0;
    localparam ST_LEAK = 2'd1;
    localparam ST_ON = 2'd2;
    localparam ST_HOLD = 2'd3;
    localparam SYN_W = 18;
    localparam [31:0] OC_LIM = `MRG_OC_CYC;
    localparam [31:0] GS_LIM = `MRG_GS_CYC;
    localparam [31:0] LEAK_LIM = `MRG_LEAK_CYC;

    wire [SYN_W-1:0] syn;
    wire pin_req;
    wire oc_cmp;
    wire gs_cmp;
    wire ss_cmp;
    wire src_ok;
    wire vdd_uv;
    wire bat_ov;
    wire bat_uv;
    wire wd_flt;
    wire ext_rst;
    wire lowside_on;
    wire [7:0] lowside_s;
    reg [11:0] ctrl_reg;
    reg [`MRG_FL_W-1:0] fault_reg;
    reg [`MRG_FL_W-1:0] fault_next;
    reg [`MRG_FL_W-1:0] irq_en_reg;
    reg [1:0] state_reg;
    reg [1:0] state_next;
    reg watchdog_status_reg;
    wire request;
    wire wd_block;
    wire hard_block;
    wire oc_trip;
    wire gs_check;
    wire leak_done;
    wire oc_kill;
    wire gs_kill;
    wire ss_kill;
    wire ov_kill;
    wire lg_fault;
    wire [`MRG_FL_W-1:0] events;
    wire [`MRG_ADDR_W-1:0] a_status;
    wire [`MRG_ADDR_W-1:0] a_ctrl;
    wire [`MRG_ADDR_W-1:0] a_fault;
    wire [`MRG_ADDR_W-1:0] a_irq_en;
    wire [`MRG_ADDR_W-1:0] a_irq_clr;
    wire [`MRG_ADDR_W-1:0] a_lowside;
    wire wr;
    wire rd;
    wire mapped;
    wire [`MRG_ST_W-1:0] status_word;

    mrg_sync #(.WIDTH(SYN_W)) u_sync (
        .i_sys_clk(i_sys_clk),
        .i_rst(i_rst),
        // Reset pin enters inverted so the cleared sync state reads as released
        .i_async({i_low_side_drivers, ~i_reset_pin_n, i_watchdog_fault, i_bat_undervoltage,
                  i_bat_overvoltage, i_vdd_undervoltage, i_source_above_vdd,
                  i_source_short_cmp, i_gate_short_cmp, i_overcurrent_cmp, i_main_relay_ctrl_pin}),
        .o_sync(syn)
    );
    assign pin_req = syn[0];
    assign oc_cmp = syn[1];
    assign gs_cmp = syn[2];
    assign ss_cmp = syn[3];
    assign src_ok = syn[4];
    assign vdd_uv = syn[5];
    assign bat_ov = syn[6];
    assign bat_uv = syn[7];
    assign wd_flt = syn[8];
    assign ext_rst = syn[9];
    assign lowside_s = syn[SYN_W-1:SYN_W-8];
    assign lowside_on = |lowside_s;

    assign request = pin_req | ctrl_reg[`MRG_CTRL_GATE_EN];
    assign wd_block = ctrl_reg[`MRG_CTRL_WATCHDOG_SUPERVISE_ENABLE] & wd_flt;
    assign hard_block = vdd_uv | bat_uv | wd_block | ext_rst;
    assign ov_kill = bat_ov & ctrl_reg[`MRG_CTRL_OV_RESP];
    assign oc_kill = oc_trip & ~ctrl_reg[`MRG_CTRL_OC_SEL];
    assign gs_kill = gs_check & gs_cmp & ~ctrl_reg[`MRG_CTRL_GS_SEL];
    assign ss_kill = (state_reg == ST_ON) & ss_cmp & ~ctrl_reg[`MRG_CTRL_SS_SEL];
    assign lg_fault = (state_reg == ST_OFF) & request & lowside_on;

    mrg_timer u_oc_timer (
        .i_sys_clk(i_sys_clk),
        .i_rst(i_rst),
        .i_run(oc_cmp && (state_reg == ST_ON)),
        .i_limit(OC_LIM[`MRG_CNT_W-1:0]),
        .o_done(oc_trip)
    );
    mrg_timer u_gs_timer (
        .i_sys_clk(i_sys_clk),
        .i_rst(i_rst),
        .i_run(state_reg == ST_ON),
        .i_limit(GS_LIM[`MRG_CNT_W-1:0]),
        .o_done(gs_check)
    );
    mrg_timer u_leak_timer (
        .i_sys_clk(i_sys_clk),
        .i_rst(i_rst),
        .i_run(state_reg == ST_LEAK),
        .i_limit(LEAK_LIM[`MRG_CNT_W-1:0]),
        .o_done(leak_done)
    );

    always @* begin
        state_next = state_reg;
        case (state_reg)
            ST_OFF: begin
                if (request && !hard_block && !ov_kill) begin
                    if (!lowside_on || ctrl_reg[`MRG_CTRL_LG_SEL]) begin
                        state_next = ST_LEAK;
                    end
                end
            end
            ST_LEAK: begin
                if (!request || hard_block || ov_kill) begin
                    state_next = ST_OFF;
                end else if (leak_done) begin
                    state_next = src_ok ? ST_ON : ST_HOLD;
                end
            end
            ST_ON: begin
                if (!request || hard_block || ov_kill || oc_kill || gs_kill || ss_kill) begin
                    state_next = ST_HOLD;
                end
            end
            ST_HOLD: begin
                // Request must drop before a new turn-on attempt
                if (!request) begin
                    state_next = ST_OFF;
                end
            end
            default: state_next = ST_OFF;
        endcase
    end

    assign events[`MRG_FL_OC] = oc_trip;
    assign events[`MRG_FL_GS] = gs_check & gs_cmp;
    assign events[`MRG_FL_SS] = (state_reg == ST_ON) & ss_cmp;
    assign events[`MRG_FL_LG] = lg_fault;
    assign events[`MRG_FL_LEAK] = (state_reg == ST_LEAK) & leak_done & ~src_ok;
    assign events[`MRG_FL_OV] = bat_ov;
    assign events[`MRG_FL_UV] = bat_uv;
    assign events[`MRG_FL_POR] = vdd_uv;
    assign events[`MRG_FL_WD] = wd_block;
    assign events[`MRG_FL_ERST] = ext_rst;

    assign a_status = {`MRG_IDX_STATUS, 2'b00};
    assign a_ctrl = {`MRG_IDX_CTRL, 2'b00};
    assign a_fault = {`MRG_IDX_FAULT, 2'b00};
    assign a_irq_en = {`MRG_IDX_IRQ_EN, 2'b00};
    assign a_irq_clr = {`MRG_IDX_IRQ_CLR, 2'b00};
    assign a_lowside = {`MRG_IDX_LOWSIDE, 2'b00};
    assign wr = i_psel & i_penable & i_pwrite;
    assign rd = i_psel & i_penable & ~i_pwrite;
    assign mapped = (i_paddr == a_status) | (i_paddr == a_ctrl) | (i_paddr == a_fault) |
                    (i_paddr == a_irq_en) | (i_paddr == a_irq_clr) | (i_paddr == a_lowside);
    assign o_pready = 1'b1;
    assign o_pslverr = i_psel & i_penable & ~mapped;

    always @* begin
        fault_next = fault_reg;
        // Status read clears flags whose cause has gone
        if (rd && i_paddr == a_status) begin
            fault_next = fault_reg & events;
        end
        if (wr && i_paddr == a_irq_clr) begin
            fault_next = fault_next & ~i_pwdata[`MRG_FL_W-1:0];
        end
        fault_next = fault_next | events;
    end

    assign status_word[`MRG_ST_POR] = fault_reg[`MRG_FL_POR];
    assign status_word[`MRG_ST_OV] = fault_reg[`MRG_FL_OV];
    assign status_word[`MRG_ST_UV] = fault_reg[`MRG_FL_UV];
    assign status_word[`MRG_ST_WATCHDOG_STATUS] = watchdog_status_reg;
    assign status_word[`MRG_ST_WDFAULT] = fault_reg[`MRG_FL_WD];
    assign status_word[`MRG_ST_ERST] = fault_reg[`MRG_FL_ERST];
    assign status_word[`MRG_ST_HSSUM] = |fault_reg[`MRG_FL_LG:`MRG_FL_OC];

    always @(posedge i_sys_clk) begin
        if (i_rst) begin
            ctrl_reg <= `MRG_CTRL_RESET;
            fault_reg <= {`MRG_FL_W{1'b0}};
            irq_en_reg <= {`MRG_FL_W{1'b0}};
            state_reg <= ST_OFF;
            watchdog_status_reg <= 1'b1;
            o_main_relay_gate <= 1'b0;
            o_leak_test_current <= 1'b0;
            o_prdata <= 32'h0000_0000;
        end else begin
            state_reg <= state_next;
            fault_reg <= fault_next;
            watchdog_status_reg <= ~wd_block;
            o_main_relay_gate <= (state_next == ST_ON);
            o_leak_test_current <= (state_next == ST_LEAK);
            if (wr && i_paddr == a_ctrl) begin
                ctrl_reg <= i_pwdata[11:0];
            end
            if (wr && i_paddr == a_irq_en) begin
                irq_en_reg <= i_pwdata[`MRG_FL_W-1:0];
            end
            if (i_psel && !i_penable && !i_pwrite) begin
                o_prdata <= 32'h0000_0000;
                if (i_paddr == a_status) begin
                    o_prdata <= {{(32-`MRG_ST_W){1'b0}}, status_word};
                end
                if (i_paddr == a_ctrl) begin
                    o_prdata <= {20'h00000, ctrl_reg};
                end
                if (i_paddr == a_fault) begin
                    o_prdata <= {{(32-`MRG_FL_W){1'b0}}, fault_reg};
                end
                if (i_paddr == a_irq_en) begin
                    o_prdata <= {{(32-`MRG_FL_W){1'b0}}, irq_en_reg};
                end
                if (i_paddr == a_lowside) begin
                    o_prdata <= {24'h000000, lowside_s};
                end
            end
        end
    end

    assign o_reset_pin_n_out = 1'b0;
    assign o_reset_pin_n_oe = vdd_uv;
    assign o_irq = |(fault_reg & irq_en_reg);
endmodule // mrg_gate_ctrl

// ==== rtl/mrg_consts.vh ====
`ifndef MRG_CONSTS_VH
`define MRG_CONSTS_VH
// Register indices, not APB byte addresses; the byte address is the index times four (0x11 is at 0x44)
`define MRG_IDX_STATUS 8'h00
`define MRG_IDX_CTRL 8'h11
`define MRG_IDX_FAULT 8'h12
`define MRG_IDX_IRQ_EN 8'h13
`define MRG_IDX_IRQ_CLR 8'h14
`define MRG_IDX_LOWSIDE 8'h15
`define MRG_ADDR_W 10
// Control register field positions
`define MRG_CTRL_GATE_EN 2
`define MRG_CTRL_WATCHDOG_SUPERVISE_ENABLE 4
`define MRG_CTRL_OV_RESP 5
`define MRG_CTRL_OC_SEL 8
`define MRG_CTRL_GS_SEL 9
`define MRG_CTRL_SS_SEL 10
`define MRG_CTRL_LG_SEL 11
`define MRG_CTRL_RESET 12'h000
// Status register (index 0x00) bits
`define MRG_ST_POR 0
`define MRG_ST_OV 1
`define MRG_ST_UV 2
`define MRG_ST_WATCHDOG_STATUS 3
`define MRG_ST_WDFAULT 4
`define MRG_ST_ERST 5
`define MRG_ST_HSSUM 6
`define MRG_ST_W 7
// Fault register bits, also the interrupt layout
`define MRG_FL_OC 0
`define MRG_FL_GS 1
`define MRG_FL_SS 2
`define MRG_FL_LG 3
`define MRG_FL_LEAK 4
`define MRG_FL_OV 5
`define MRG_FL_UV 6
`define MRG_FL_POR 7
`define MRG_FL_WD 8
`define MRG_FL_ERST 9
`define MRG_FL_W 10
// Timing in ns at 100 MHz (10 ns period)
`define MRG_CLK_NS 10
`define MRG_OC_DEGLITCH_NS 10000
`define MRG_GS_DELAY_NS 20000
`define MRG_LEAK_TIME_NS 40000
`define MRG_OC_CYC ((`MRG_OC_DEGLITCH_NS + `MRG_CLK_NS - 1) / `MRG_CLK_NS)
`define MRG_GS_CYC ((`MRG_GS_DELAY_NS + `MRG_CLK_NS - 1) / `MRG_CLK_NS)
`define MRG_LEAK_CYC ((`MRG_LEAK_TIME_NS + `MRG_CLK_NS - 1) / `MRG_CLK_NS)
`define MRG_CNT_W 13
`endif

// ==== rtl/mrg_sync.v ====
`timescale 1ns/10ps
module mrg_sync #(
    parameter WIDTH = 8
) (
    input wire i_sys_clk,
    input wire i_rst,
    input wire [WIDTH-1:0] i_async,
    output reg [WIDTH-1:0] o_sync
);
    reg [WIDTH-1:0] meta_reg;
    always @(posedge i_sys_clk) begin
        if (i_rst) begin
            meta_reg <= {WIDTH{1'b0}};
            o_sync <= {WIDTH{1'b0}};
        end else begin
            meta_reg <= i_async;
            o_sync <= meta_reg;
        end
    end
endmodule // mrg_sync

// ==== rtl/mrg_timer.v ====
`timescale 1ns/10ps
`include "mrg_consts.vh"
// Counts while i_run is high; o_done once the count reaches i_limit
module mrg_timer (
    input wire i_sys_clk,
    input wire i_rst,
    input wire i_run,
    input wire [`MRG_CNT_W-1:0] i_limit,
    output wire o_done
);
    reg [`MRG_CNT_W-1:0] cnt_reg;
    always @(posedge i_sys_clk) begin
        if (i_rst || !i_run) begin
            cnt_reg <= {`MRG_CNT_W{1'b0}};
        end else if (cnt_reg != i_limit) begin
            cnt_reg <= cnt_reg + 1'b1;
        end
    end
    assign o_done = i_run && (cnt_reg == i_limit);
endmodule // mrg_timer

// ==== verif/mrg_relay_model.sv ====
`timescale 1ns/10ps
// Switch and load: the source charges from the test current unless the load leaks
module mrg_relay_model (
    input wire i_sys_clk,
    input wire i_gate,
    input wire i_leak_current,
    input wire i_leaky,
    input wire i_oc_cmd,
    output logic o_source_above_vdd,
    output logic o_overcurrent_cmp
);
    int charge = 0;
    initial begin
        o_source_above_vdd = 1'h0;
        o_overcurrent_cmp = 1'h0;
    end
    always @(posedge i_sys_clk) begin
        charge <= (i_leak_current && !i_leaky) ? charge + 1 : 0;
        o_source_above_vdd <= i_gate || charge > 20;
        o_overcurrent_cmp <= i_gate && i_oc_cmd;
    end
endmodule // mrg_relay_model

// ==== verif/mrg_gate_ctrl_chk.sv ====
`timescale 1ns/10ps
`include "mrg_consts.vh"
module mrg_gate_ctrl_chk (
    input wire i_sys_clk,
    input wire i_rst,
    input wire i_psel,
    input wire i_penable,
    input wire i_pwrite,
    input wire [9:0] i_paddr,
    input wire [31:0] i_pwdata,
    input wire i_main_relay_ctrl_pin,
    input wire i_overcurrent_cmp,
    input wire i_source_above_vdd,
    input wire i_vdd_undervoltage,
    input wire i_bat_overvoltage,
    input wire i_bat_undervoltage,
    input wire i_watchdog_fault,
    input wire i_reset_pin_n,
    input wire o_main_relay_gate,
    input wire o_leak_test_current,
    input wire o_reset_pin_n_oe
);
    logic [11:0] c;
    logic [10:0] oc_cnt_reg;
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (i_rst);
    // Shadow of the control register
    always @(posedge i_sys_clk) begin
        if (i_rst) begin
            c <= 12'h000;
        end else if (i_psel && i_penable && i_pwrite && i_paddr == 10'h044) begin
            c <= i_pwdata[11:0];
        end
    end
    always @(posedge i_sys_clk) begin
        if (i_rst || !i_overcurrent_cmp) begin
            oc_cnt_reg <= 11'h000;
        end else if (oc_cnt_reg != 11'h7ff) begin
            oc_cnt_reg <= oc_cnt_reg + 11'h001;
        end
    end
    sequence held4(x);
        x [*4];
    endsequence
    req_gate_a:
        assert property (held4(!i_main_relay_ctrl_pin && !c[`MRG_CTRL_GATE_EN]) |-> !o_main_relay_gate) else $error("gate");
    leak_first_a:
        assert property ($rose(o_main_relay_gate) |-> $past(o_leak_test_current)) else $error("no leak test");
    leak_fail_a:
        assert property (held4(!i_source_above_vdd) ##1 !i_source_above_vdd |-> !$rose(o_main_relay_gate)) else $error("leak");
    uv_off_a:
        assert property (held4(i_vdd_undervoltage) |-> !o_main_relay_gate && o_reset_pin_n_oe) else $error("vdd uv");
    bat_off_a:
        assert property (held4(i_bat_undervoltage) |-> !o_main_relay_gate) else $error("bat uv");
    wd_off_a:
        assert property (held4(i_watchdog_fault && c[`MRG_CTRL_WATCHDOG_SUPERVISE_ENABLE]) |-> !o_main_relay_gate) else $error("wd");
    ov_off_a:
        assert property (held4(i_bat_overvoltage && c[`MRG_CTRL_OV_RESP]) |-> !o_main_relay_gate) else $error("ov");
    erst_off_a:
        assert property (held4(!i_reset_pin_n) |-> !o_main_relay_gate) else $error("ext reset");
    oc_trip_a:
        assert property (oc_cnt_reg > 11'h3f2 && !c[`MRG_CTRL_OC_SEL] |-> !o_main_relay_gate) else $error("oc trip");
    oc_glitch_a:
        assert property ($fell(o_main_relay_gate) && i_overcurrent_cmp |-> oc_cnt_reg > 11'h3e0) else $error("oc early");
endmodule // mrg_gate_ctrl_chk
bind mrg_gate_ctrl mrg_gate_ctrl_chk mrg_gate_ctrl_chk_inst (.*);

// ==== verif/mrg_gate_ctrl_tb.sv ====
`timescale 1ns/10ps
`include "mrg_consts.vh"
module mrg_gate_ctrl_tb;
    logic clk = 1'h0, rst = 1'h1, psel = 1'h0, pen = 1'h0, pwr = 1'h0, pin = 1'h0, gs = 1'h0, ss = 1'h0;
    logic vuv = 1'h0, bov = 1'h0, buv = 1'h0, wdf = 1'h0, ext_n = 1'h1, leaky = 1'h0, occ = 1'h0;
    logic [9:0] paddr = 10'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd, ctrl;
    logic [7:0] lsd = 8'h00;
    logic pready, pslverr, err, gate, leak, rout, roe, irq, oc, src;
    wire rpin = roe ? rout : ext_n;
    int fails = 0, comparisons = 0;
    int fb [8] = '{0, 1, 2, 7, 6, 8, 9, 5};
    always #5 clk = ~clk;
    mrg_gate_ctrl mrg_gate_ctrl_inst (.i_sys_clk(clk), .i_rst(rst), .i_psel(psel), .i_penable(pen),
        .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
        .o_pslverr(pslverr), .i_main_relay_ctrl_pin(pin), .i_overcurrent_cmp(oc), .i_gate_short_cmp(gs),
        .i_source_short_cmp(ss), .i_source_above_vdd(src), .i_vdd_undervoltage(vuv), .i_bat_overvoltage(bov),
        .i_bat_undervoltage(buv), .i_watchdog_fault(wdf), .i_reset_pin_n(rpin), .i_low_side_drivers(lsd),
        .o_main_relay_gate(gate), .o_leak_test_current(leak), .o_reset_pin_n_out(rout),
        .o_reset_pin_n_oe(roe), .o_irq(irq));
    mrg_relay_model mrg_relay_model_inst (.i_sys_clk(clk), .i_gate(gate), .i_leak_current(leak),
        .i_leaky(leaky), .i_oc_cmd(occ), .o_source_above_vdd(src), .o_overcurrent_cmp(oc));
    task chk(input logic [32:0] s, input logic [32:0] e);
        comparisons++;
        if (s !== e) begin
            fails++;
            $display("[FAIL] %0t got %h expected %h", $time, s, e);
        end
    endtask
    task apb(input logic w, input logic [9:0] a, input logic [31:0] d);
        psel <= 1'h1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'h1;
        @(posedge clk);
        while (pready !== 1'h1) @(posedge clk);
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        pen <= 1'h0;
        @(posedge clk);
    endtask
    // Drop the request, clear flags, then request again by pin or by control bit
    task req(input logic e, input logic by_pin);
        int n;
        pin <= 1'h0;
        apb(1'h1, 10'h044, ctrl);
        apb(1'h0, 10'h000, 32'h0);
        if (by_pin) pin <= 1'h1;
        else apb(1'h1, 10'h044, ctrl | 32'h4);
        for (n = 0; n < 4100 && (gate !== 1'h1 || !e); n++) begin
            @(posedge clk);
            if (n == 100 && lsd == 8'h00) chk(leak, 1'h1);
        end
        chk(gate, e);
    endtask
    task hit(input int k, input logic v);
        case (k)
            0: occ <= v;
            1: gs <= v;
            2: ss <= v;
            3: vuv <= v;
            4: buv <= v;
            5: wdf <= v;
            6: ext_n <= !v;
            default: bov <= v;
        endcase
    endtask
    function automatic logic exp_gate(input int k, input logic [31:0] c);
        case (k)
            0: return c[`MRG_CTRL_OC_SEL];
            1: return c[`MRG_CTRL_GS_SEL];
            2: return c[`MRG_CTRL_SS_SEL];
            5: return !c[`MRG_CTRL_WATCHDOG_SUPERVISE_ENABLE];
            7: return !c[`MRG_CTRL_OV_RESP];
            default: return 1'h0;
        endcase
    endfunction
    task end_of_test();
        $display("fails=%0d comparisons=%0d", fails, comparisons);
        if (fails == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    initial begin
        repeat (95000) @(posedge clk);
        fails++;
        end_of_test();
    end
    initial begin
        int k, p;
        void'($urandom(36879));
        repeat (8) @(posedge clk);
        rst <= 1'h0;
        apb(1'h0, 10'h044, 32'h0);
        chk(rd, 32'h0);
        for (p = 0; p < 2; p++) begin
            ctrl = p ? 32'hf00 : 32'h030;
            apb(1'h1, 10'h04c, 32'h3ff);
            for (k = 0; k < 8; k++) begin
                req(1'h1, k[0]);
                hit(k, 1'h1);
                repeat (12) @(posedge clk);
                if (k < 2) chk(gate, 1'h1);
                repeat (k == 0 ? 1100 : k == 1 ? 2100 : 0) @(posedge clk);
                chk(gate, exp_gate(k, ctrl));
                apb(1'h0, 10'h048, 32'h0);
                if (p == 0 || k != 5) chk(rd[fb[k]], 1'h1);
                if (k < 3) chk(irq, 1'h1);
                apb(1'h0, 10'h000, 32'h0);
                if (k < 3) chk(rd[`MRG_ST_HSSUM], 1'h1);
                if (k == 3) chk(roe, 1'h1);
                if (k == 5 && p == 0) chk(rd[`MRG_ST_WDFAULT:`MRG_ST_WATCHDOG_STATUS], 2'h2);
                hit(k, 1'h0);
                repeat (4) @(posedge clk);
                apb(1'h0, 10'h000, 32'h0);
                apb(1'h0, 10'h048, 32'h0);
                chk(rd[fb[k]], 1'h0);
            end
        end
        apb(1'h1, 10'h04c, 32'h0);
        buv <= 1'h1;
        repeat (6) @(posedge clk);
        chk(irq, 1'h0);
        apb(1'h1, 10'h04c, 32'h3ff);
        chk(irq, 1'h1);
        buv <= 1'h0;
        repeat (4) @(posedge clk);
        apb(1'h1, 10'h050, 32'h3ff);
        chk(irq, 1'h0);
        leaky <= 1'h1;
        req(1'h0, 1'h1);
        apb(1'h0, 10'h048, 32'h0);
        chk(rd[`MRG_FL_LEAK], 1'h1);
        leaky <= 1'h0;
        lsd <= 8'($urandom) | 8'h01;
        ctrl = 32'h000;
        req(1'h0, 1'h0);
        apb(1'h0, 10'h048, 32'h0);
        chk(rd[`MRG_FL_LG], 1'h1);
        ctrl = 32'h800;
        req(1'h1, 1'h1);
        lsd <= 8'h00;
        apb(1'h0, 10'h100 | 10'($urandom) & 10'h0fc, 32'h0);
        chk({err, rd}, 33'h100000000);
        end_of_test();
    end
endmodule // mrg_gate_ctrl_tb
